/* File: drs_readback_top.sv */
/*
   Register bank, status register and readback control of a quad
   current-output DAC serial port.
   Assumes fault, ramp and strap inputs come from other domains and a
   packet checker that toggles its event line once per failed word.
*/
`include "drs_defines.svh"

module drs_readback_top
   import drs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        linkClk,
   input  wire logic        frameSelN,
   input  wire logic        serialIn,
   output logic             serialOut,
   input  wire logic [1:0]  devAddrPin,
   input  wire logic [3:0]  boostComplianceFlag,
   input  wire logic [3:0]  outputFault,
   input  wire logic        overTemp,
   input  wire logic [3:0]  rampBusy,
   input  wire logic        packetCheckFailToggle,
   output logic [3:0]       rampEnable,
   output logic [15:0]      rampUpdateRate,
   output logic [11:0]      rampStepSize,
   output logic             statusEveryWrite
);

   drs_link_if lnk ();

   drs_serial_link uLink (
      .nrst      (nrst),
      .linkClk   (linkClk),
      .frameSelN (frameSelN),
      .serialIn  (serialIn),
      .serialOut (serialOut),
      .lnk       (lnk.link)
   );

   // ==========================================================
   // Pin synchronisers
   logic [15:0] pinMeta;
   logic [15:0] pinSync;
   logic        pecTogglePrev;
   logic [2:0]  frameSync;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pinMeta <= 16'h0000;
         pinSync <= 16'h0000;
      end else begin
         pinMeta <= {devAddrPin, boostComplianceFlag, outputFault, overTemp, rampBusy,
                     packetCheckFailToggle};
         pinSync <= pinMeta;
      end
   end

   logic [1:0] devAddrSync;
   logic [3:0] complSync;
   logic [3:0] faultSync;
   logic       overTempSync;
   logic [3:0] rampSync;
   logic       pecToggleSync;

   assign devAddrSync   = pinSync[15:14];
   assign complSync     = pinSync[13:10];
   assign faultSync     = pinSync[9:6];
   assign overTempSync  = pinSync[5];
   assign rampSync      = pinSync[4:1];
   assign pecToggleSync = pinSync[0];

   // ==========================================================
   // Frame event crossing
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         frameSync <= 3'h0;
      end else begin
         frameSync <= {frameSync[1:0], lnk.frameToggle};
      end
   end

   logic     frameStrobe;
   drs_cmd_t cmd;
   logic     addrMatch;
   logic     isRead;
   logic     isWrite;

   assign frameStrobe = frameSync[2] ^ frameSync[1];
   assign cmd         = lnk.rxFrame;
   assign addrMatch   = (cmd.devAddr == devAddrSync);
   assign isRead      = frameStrobe && addrMatch && cmd.readReq;
   assign isWrite     = frameStrobe && addrMatch && !cmd.readReq;

   // ==========================================================
   // Register file
   drs_reg_t regFile [0:`DRS_NUM_REGS-1];
   logic     userToggle;
   logic     isRampWrite;

   assign isRampWrite = (cmd.data[15:13] == `DRS_RAMP_ID);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < `DRS_NUM_REGS; i++) begin
            if (i >= 8 && i < 12) begin
               regFile[i] <= `DRS_RST_GAIN;
            end else if (i >= 12 && i < 16) begin
               regFile[i] <= `DRS_RST_OFFSET;
            end else begin
               regFile[i] <= `DRS_RST_ZERO;
            end
         end
      end else if (isWrite) begin
         case (cmd.sel[4:2])
            3'h0, 3'h2, 3'h3, 3'h4: begin
               regFile[cmd.sel] <= cmd.data;
            end
            3'h1: begin
               if (isRampWrite) begin
                  regFile[`DRS_SEL_RAMP + cmd.sel[1:0]] <= cmd.data;
               end else begin
                  regFile[cmd.sel] <= cmd.data;
               end
            end
            3'h6: begin
               if (cmd.sel == `DRS_SEL_MAIN || cmd.sel == `DRS_SEL_BOOST) begin
                  regFile[cmd.sel] <= cmd.data;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         userToggle <= 1'b0;
      end else if (isWrite && cmd.sel == `DRS_SEL_SOFT) begin
         userToggle <= cmd.data[`DRS_SOFT_TOGGLE_BIT];
      end
   end

   // ==========================================================
   // Ramp control outputs per channel
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch++) begin : gRamp
         assign rampEnable[ch] = regFile[`DRS_SEL_RAMP + ch][`DRS_RAMP_EN_BIT];
         assign rampUpdateRate[4*ch+3:4*ch] =
            regFile[`DRS_SEL_RAMP + ch][`DRS_RAMP_RATE_HI:`DRS_RAMP_RATE_LO];
         assign rampStepSize[3*ch+2:3*ch] =
            regFile[`DRS_SEL_RAMP + ch][`DRS_RAMP_STEP_HI:`DRS_RAMP_STEP_LO];
      end
   endgenerate

   assign statusEveryWrite = regFile[`DRS_SEL_MAIN][`DRS_MAIN_SEW_BIT];

   // ==========================================================
   // Status register, built from internal conditions and the user toggle
   logic     packetCheckFail;
   drs_reg_t statusWord;
   drs_ret_t nextRet;
   logic     statusShown;

   always_comb begin
      statusWord        = `DRS_RST_ZERO;
      statusWord[15:12] = complSync;
      statusWord[11]    = userToggle;
      statusWord[10]    = packetCheckFail;
      statusWord[9]     = |rampSync;
      statusWord[8]     = overTempSync;
      statusWord[3:0]   = faultSync | complSync;
   end

   assign statusShown = frameStrobe && (nextRet == DRS_RET_STATUS);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pecTogglePrev <= 1'b0;
      end else begin
         pecTogglePrev <= pecToggleSync;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         packetCheckFail <= 1'b0;
      end else if (pecToggleSync ^ pecTogglePrev) begin
         packetCheckFail <= 1'b1;
      end else if (statusShown) begin
         packetCheckFail <= 1'b0;
      end
   end

   // ==========================================================
   // Answer selection for the following frame
   always_comb begin
      nextRet = DRS_RET_NONE;
      if (isRead) begin
         if (cmd.sel == `DRS_SEL_STATUS) begin
            nextRet = DRS_RET_STATUS;
         end else if (statusEveryWrite) begin
            nextRet = DRS_RET_NONE;
         end else if (cmd.sel <= `DRS_SEL_BOOST) begin
            nextRet = DRS_RET_REG;
         end
      end else if (frameStrobe && statusEveryWrite) begin
         nextRet = DRS_RET_STATUS;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         lnk.txFrame <= 24'h00_0000;
      end else if (frameStrobe) begin
         case (nextRet)
            DRS_RET_REG: begin
               lnk.txFrame <= {1'b0, devAddrSync, cmd.sel, regFile[cmd.sel]};
            end
            DRS_RET_STATUS: begin
               lnk.txFrame <= {1'b0, devAddrSync, `DRS_SEL_STATUS, statusWord};
            end
            default: begin
               lnk.txFrame <= 24'h00_0000;
            end
         endcase
      end
   end

endmodule : drs_readback_top

/* File: drs_defines.svh */
/*
   Constants of the DAC readback and status block: frame layout, read
   selector codes, register field positions and reset values.
   Assumes it is included once per compilation unit by its bare name.
*/
//
// Function
// - Frame bit 23 high marks a read request, never a register write.
// - Device address bits with selector bits 20..16 choose the register returned.
// - Low sixteen bits of a read request change nothing.
// - The transfer after a read request shifts the selected register out.
// - Selectors 0..15 return data, control, gain and offset registers A..D.
// - Selectors 16..23 return clear code, then ramp control registers A..D.
// - Selectors 24, 25, 26 return status, main control, boost control.
// - Status is read only; it shows internal conditions and the user toggle.
// - Status-on-every-write set shifts status out in the frame after every write frame.
// - Bits 15..12 flag boost compliance loss per channel, forcing that fault.
// - Status bit 11 follows the user toggle written via software register.
// - Status bit 10 flags a packet check failure on the last word.
// - Status bit 9 is high while any channel ramps.
// - Status bit 8 reports core over-temperature.
// - Bits 3..0 flag output faults D..A; bits 7..4 read zero.
// - Ramp control write has top bits 000: enable, rate, step fields.
// - Ramp control is held and programmed separately for each channel.
// - With status-on-every-write set, only status can be read back.
// - Reading status clears the packet check failure bit.
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// ==========================================================
// Frame layout
`define DRS_FRAME_BITS      24
`define DRS_BIT_CNT_LAST    5'h17
`define DRS_BIT_CNT_DONE    5'h18

// ==========================================================
// Read selector codes
`define DRS_SEL_DATA        5'h00
`define DRS_SEL_CTRL        5'h04
`define DRS_SEL_GAIN        5'h08
`define DRS_SEL_OFFSET      5'h0C
`define DRS_SEL_CLEAR       5'h10
`define DRS_SEL_RAMP        5'h14
`define DRS_SEL_STATUS      5'h18
`define DRS_SEL_MAIN        5'h19
`define DRS_SEL_BOOST       5'h1A
`define DRS_SEL_SOFT        5'h1B
`define DRS_NUM_REGS        27

// ==========================================================
// Register fields
`define DRS_RAMP_ID         3'h0
`define DRS_RAMP_EN_BIT     12
`define DRS_RAMP_RATE_HI    6
`define DRS_RAMP_RATE_LO    3
`define DRS_RAMP_STEP_HI    2
`define DRS_RAMP_STEP_LO    0
`define DRS_MAIN_SEW_BIT    11
`define DRS_SOFT_TOGGLE_BIT 12

// ==========================================================
// Reset values
`define DRS_RST_ZERO        16'h0000
`define DRS_RST_GAIN        16'hFFFF
`define DRS_RST_OFFSET      16'h8000

`endif

/* File: drs_pkg.sv */
/*
   Types of the DAC readback and status block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package drs_pkg;

   // ==========================================================
   // Register word and received command frame
   typedef logic [15:0] drs_reg_t;

   typedef struct packed {
      logic       readReq;
      logic [1:0] devAddr;
      logic [4:0] sel;
      drs_reg_t   data;
   } drs_cmd_t;

   // ==========================================================
   // What the next frame shifts out
   typedef enum {
      DRS_RET_NONE,
      DRS_RET_REG,
      DRS_RET_STATUS
   } drs_ret_t;

endpackage : drs_pkg

/* File: drs_link_if.sv */
/*
   Signals between the serial link logic and the register core.
   Assumes rxFrame and frameToggle change on the link clock only and
   txFrame on the core clock only.
*/
interface drs_link_if;
   import drs_pkg::*;

   drs_cmd_t    rxFrame;
   logic        frameToggle;
   logic [23:0] txFrame;

   modport link (output rxFrame, output frameToggle, input txFrame);
   modport core (input rxFrame, input frameToggle, output txFrame);

endinterface : drs_link_if

/* File: drs_serial_link.sv */
/*
   Serial shifter on the link clock: gathers 24-bit frames, flags each
   completed frame by a toggle, shifts the prepared answer out.
   Assumes the host drives data on the falling edge, samples on the rising
   edge, holds frameSelN high between frames and leaves a frame gap.
*/
`include "drs_defines.svh"

module drs_serial_link
   import drs_pkg::*;
(
   input  wire logic  nrst,
   input  wire logic  linkClk,
   input  wire logic  frameSelN,
   input  wire logic  serialIn,
   output logic       serialOut,
   drs_link_if.link   lnk
);

   logic [4:0]  bitCount;
   logic [22:0] shiftIn;
   logic        frameRstN;

   assign frameRstN = nrst & ~frameSelN;

   // ==========================================================
   // Bit counter, cleared by the frame signal itself
   always_ff @(posedge linkClk or negedge frameRstN) begin
      if (!frameRstN) begin
         bitCount <= 5'h00;
      end else if (bitCount != `DRS_BIT_CNT_DONE) begin
         bitCount <= bitCount + 5'h01;
      end
   end

   // ==========================================================
   // Input shifter and frame capture
   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         shiftIn <= 23'h00_0000;
      end else if (!frameSelN && bitCount < `DRS_BIT_CNT_LAST) begin
         shiftIn <= {shiftIn[21:0], serialIn};
      end
   end

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         lnk.rxFrame     <= '0;
         lnk.frameToggle <= 1'b0;
      end else if (!frameSelN && bitCount == `DRS_BIT_CNT_LAST) begin
         lnk.rxFrame     <= {shiftIn, serialIn};
         lnk.frameToggle <= ~lnk.frameToggle;
      end
   end

   // ==========================================================
   // Answer shifter, MSB first; bit 23 of an answer is always zero
   always_ff @(negedge linkClk or negedge nrst) begin
      if (!nrst) begin
         serialOut <= 1'b0;
      end else if (bitCount != 5'h00 && bitCount != `DRS_BIT_CNT_DONE) begin
         serialOut <= lnk.txFrame[5'h17 - bitCount];
      end else begin
         serialOut <= 1'b0;
      end
   end

endmodule : drs_serial_link

/* File: drs_readback_chk.sv */
/*
   Port checker of the readback block, bound into drs_readback_top.
   Assumes the host sends whole 24-bit frames and leaves a frame gap.
*/
module drs_readback_chk
   import drs_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        linkClk,
   input wire logic        frameSelN,
   input wire logic        serialIn,
   input wire logic        serialOut,
   input wire logic [1:0]  devAddrPin,
   input wire logic [3:0]  rampEnable,
   input wire logic [15:0] rampUpdateRate,
   input wire logic [11:0] rampStepSize,
   input wire logic        statusEveryWrite
);
   logic [23:0] shReg;
   logic [4:0]  bitCnt;
   logic [32:0] outs;
   logic        rampWr;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // Last frame and bit count on the link
   assign outs   = {rampEnable, rampUpdateRate, rampStepSize, statusEveryWrite};
   assign rampWr = shReg[23:18] == {1'b0, devAddrPin, 3'b001} && shReg[15:13] == 3'b000;

   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) shReg <= 24'h00_0000;
      else shReg <= {shReg[22:0], serialIn};
   end

   always_ff @(posedge linkClk or posedge frameSelN) begin
      if (frameSelN) bitCnt <= 5'h00;
      else bitCnt <= bitCnt + 5'h01;
   end

   // ==========================================================
   // Assertions
   chk_idle_low: assert property (frameSelN && $past(frameSelN, 2) |-> !serialOut)
      else $error("serial output active between frames");
   chk_frame_msb: assert property (@(posedge linkClk) disable iff (!nrst)
      bitCnt == 5'h00 |-> !serialOut) else $error("answer top bit not zero");
   chk_ramp_quiet: assert property ($changed(outs) |-> frameSelN)
      else $error("control outputs changed inside a frame");
   chk_read_nowrite: assert property ($rose(frameSelN) && shReg[23]
      |-> ##1 $stable(outs)[*8]) else $error("read frame changed a register");
   chk_foreign_addr: assert property ($rose(frameSelN) && shReg[22:21] != devAddrPin
      |-> ##1 $stable(outs)[*8]) else $error("frame for other device acted on");
   chk_sew_follow: assert property ($rose(frameSelN)
      && shReg[23:16] == {1'b0, devAddrPin, 5'h19}
      |-> ##[1:8] statusEveryWrite == shReg[11]) else $error("status-every-write wrong");
   chk_ramp_fields: assert property ($rose(frameSelN) && rampWr
      |-> ##[1:8] rampEnable[shReg[17:16]] == shReg[12]
      && rampUpdateRate[shReg[17:16]*4 +: 4] == shReg[6:3]
      && rampStepSize[shReg[17:16]*3 +: 3] == shReg[2:0]) else $error("ramp fields wrong");
   chk_ramp_other: assert property ($rose(frameSelN) && rampWr
      |-> ##1 $stable(rampEnable & ~(4'h1 << shReg[17:16]))[*8])
      else $error("ramp write touched another channel");
   chk_reset_clear: assert property ($rose(nrst) |-> outs == 33'h0_0000_0000)
      else $error("outputs not cleared by reset");

endmodule : drs_readback_chk

bind drs_readback_top drs_readback_chk u_chk (.ref_clk, .nrst, .linkClk, .frameSelN,
   .serialIn, .serialOut, .devAddrPin, .rampEnable, .rampUpdateRate, .rampStepSize,
   .statusEveryWrite);

/* File: drs_host_model.sv */
/*
   Host serial master: 24-bit frames, 12 ns link clock, idle low.
   Assumes the caller waits for each transfer to end.
*/
module drs_host_model (
   output logic      linkClk,
   output logic      frameSelN,
   output logic      serialIn,
   input  wire logic serialOut
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      linkClk   = 1'b0;
      frameSelN = 1'b1;
      serialIn  = 1'b0;
   end

   // ==========================================================
   // One frame, MSB first, answer sampled on each rise
   task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
      frameSelN = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         serialIn = tx[i];
         #6 linkClk = 1'b1;
         rx[i] = serialOut;
         #6 linkClk = 1'b0;
      end
      serialIn  = ~tx[0];
      frameSelN = 1'b1;
      #300;
   endtask : xfer

endmodule : drs_host_model

/* File: tb_dac_readback_status_logic.sv */
/*
   Self-checking bench of the readback block with a host model.
   Assumes device address strap 01 and whole frames from the host.
*/
module tb_dac_readback_status_logic;
   timeunit 1ns;
   timeprecision 1ps;

   logic        refClk = 1'b0;
   logic        nrst = 1'b0;
   logic [1:0]  devAddr = 2'b01;
   logic [3:0]  boostFlag = 4'h0;
   logic [3:0]  outFault = 4'h0;
   logic [3:0]  rampBusy = 4'h0;
   logic        overTemp = 1'b0;
   logic        pecTgl = 1'b0;
   wire         linkClk, frameSelN, serialIn, serialOut, statusEveryWrite;
   wire  [3:0]  rampEnable;
   wire  [15:0] rampUpdateRate;
   wire  [11:0] rampStepSize;
   int          error_cnt = 0;
   int          checks_done = 0;
   logic [23:0] rx;

   always #12.5 refClk = ~refClk;

   drs_readback_top DUT (.ref_clk(refClk), .nrst, .linkClk, .frameSelN, .serialIn,
      .serialOut, .devAddrPin(devAddr), .boostComplianceFlag(boostFlag),
      .outputFault(outFault), .overTemp, .rampBusy, .packetCheckFailToggle(pecTgl),
      .rampEnable, .rampUpdateRate, .rampStepSize, .statusEveryWrite);
   drs_host_model host (.linkClk, .frameSelN, .serialIn, .serialOut);

   // ==========================================================
   // Shared tasks
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [4:0] sel, input logic [15:0] d);
      host.xfer({1'b0, devAddr, sel, d}, rx);
   endtask : wr

   task rd(input logic [4:0] sel, input logic [15:0] exp);
      host.xfer({1'b1, devAddr, sel, 16'h1234}, rx);
      host.xfer(24'h1C_E000, rx);
      chk(rx, {1'b0, devAddr, sel, exp});
   endtask : rd

   // ==========================================================
   // Scenarios
   task t_reset_map;
      logic [15:0] e;
      host.xfer({1'b1, devAddr, 5'h00, 16'hFFFF}, rx);
      for (int s = 1; s <= 27; s++) begin
         e = (s > 8 && s <= 12) ? 16'hFFFF : (s > 12 && s <= 16) ? 16'h8000 : 16'h0000;
         host.xfer(s == 27 ? 24'h1C_E000 : {1'b1, devAddr, 5'(s), 16'hFFFF}, rx);
         chk(rx, {1'b0, devAddr, 5'(s - 1), e});
      end
   endtask : t_reset_map

   task t_write_back;
      wr(5'h09, 16'hA5C3);
      wr(5'h00, 16'h1357);
      wr(5'h10, 16'h2468);
      rd(5'h09, 16'hA5C3);
      rd(5'h00, 16'h1357);
      rd(5'h10, 16'h2468);
   endtask : t_write_back

   task t_ramp;
      wr(5'h05, 16'h1055);
      wr(5'h15, 16'h0000);
      chk(24'(rampEnable), 24'h00_0002);
      chk(24'(rampUpdateRate), 24'h00_00A0);
      chk(24'(rampStepSize), 24'h00_0028);
      rd(5'h15, 16'h1055);
   endtask : t_ramp

   task t_status;
      @(negedge refClk);
      boostFlag = 4'b0100;
      outFault  = 4'b0001;
      overTemp  = 1'b1;
      rampBusy  = 4'b0010;
      pecTgl    = 1'b1;
      wr(5'h1B, 16'h1000);
      wr(5'h18, 16'hFFFF);
      rd(5'h18, 16'h4F05);
      rd(5'h18, 16'h4B05);
   endtask : t_status

   task t_every_write;
      wr(5'h19, 16'h0800);
      chk(24'(statusEveryWrite), 24'h00_0001);
      wr(5'h01, 16'h2001);
      host.xfer(24'h1C_E000, rx);
      chk(rx, {1'b0, devAddr, 5'h18, 16'h4B05});
      host.xfer({1'b1, devAddr, 5'h08, 16'h0000}, rx);
      host.xfer(24'h1C_E000, rx);
      chk(24'(rx[15:0]), 24'h00_0000);
      wr(5'h19, 16'h0000);
      chk(24'(statusEveryWrite), 24'h00_0000);
   endtask : t_every_write

   task t_foreign;
      host.xfer({1'b0, 2'b10, 5'h04, 16'h1FFF}, rx);
      host.xfer({1'b1, 2'b10, 5'h08, 16'h0000}, rx);
      host.xfer(24'h1C_E000, rx);
      chk(rx, 24'h00_0000);
      chk(24'(rampEnable), 24'h00_0002);
   endtask : t_foreign

   // ==========================================================
   // Verdict, sequence and watchdog
   task results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   initial begin
      repeat (3) @(negedge refClk);
      nrst = 1'b1;
      repeat (3) @(negedge refClk);
      t_reset_map();
      t_write_back();
      t_ramp();
      t_status();
      t_every_write();
      t_foreign();
      results();
   end

   initial begin
      #200us;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      results();
   end

endmodule : tb_dac_readback_status_logic
